/* design/mcu_interrupt_controller.sv */
/*
 * Interrupt controller: request flags, enables, edge pins, group flags,
 * fixed-priority arbitration and the vectoring handshake to the sequencer.
 * Assumes the sequencer owns the stack, signals instruction boundaries
 * and the return instruction, and reports when the stack is full.
 */
// The register addresses and register access over Avalon-MM were decided locally.
// Overview of operation
// - Timebase, comparator and member flags set regardless of enables
// - Disabled flag stays set, never vectors
// - Global enable low blocks every vector
// - Take pushes next address, then loads vector
// - Return instruction pops the saved address
// - Servicing clears the global enable
// - Requests latch while global enable low
// - Full stack holds off every request
// - Simultaneous requests served by fixed priority
// - Any set flag wakes the device
// - Pin flag set on selected edge type
// - Edge codes: off, rise, fall, both
// - Pin vectors need global, pin enable, edge
// - Pin is interrupt input only when enabled
// - Pin service clears pin flag too
// - Comparator flag set on output change
// - Comparator service clears comparator flag
// - Group/timebase register: flags high, enables low
// - Timer0 register: flags 5,4, enables 1,0
// - Large variant adds timer1 match B bits
// - Peripheral register: four flags, four enables
// - Unimplemented bits read zero, ignore writes
// - Enabled member event raises its group flag
// - Group service clears group flag only
`timescale 1ns/10ps
module mcu_interrupt_controller #(
	parameter bit                                          HAS_MATCH_B = 1'b1,
	parameter logic [intc_pkg::N_VEC*intc_pkg::PC_W-1:0]  VEC_TABLE   = intc_pkg::VEC_DEFAULT,
	parameter logic [intc_pkg::N_VEC*intc_pkg::IDX_W-1:0] PRIO_MAP    = intc_pkg::PRIO_DEFAULT
) (
	// Clock and reset
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_resetn,
	input  wire logic                          i_clk_en,
	// Avalon-MM slave
	input  wire logic [intc_pkg::ADDR_W-1:0]   i_avs_address,
	input  wire logic                          i_avs_read,
	input  wire logic                          i_avs_write,
	input  wire logic [intc_pkg::DATA_W-1:0]   i_avs_writedata,
	input  wire logic [3:0]                    i_avs_byteenable,
	output logic      [intc_pkg::DATA_W-1:0]   o_avs_readdata,
	output logic                               o_avs_waitrequest,
	// Event sources
	input  wire intc_pkg::src_evt_t            i_src_evt,
	input  wire logic [1:0]                    i_ext_pin,
	input  wire logic [1:0]                    i_comp_out,
	input  wire logic                          i_ext_periph_pin_n,
	// Program sequencer
	input  wire logic                          i_insn_boundary,
	input  wire logic [intc_pkg::PC_W-1:0]     i_next_pc,
	input  wire logic                          i_stack_full,
	input  wire logic                          i_return_from_irq_instruction,
	output logic                               o_push,
	output logic      [intc_pkg::PC_W-1:0]     o_push_pc,
	output logic                               o_load,
	output logic      [intc_pkg::PC_W-1:0]     o_load_pc,
	output logic                               o_pop,
	// Power and pin control
	output logic                               o_wake,
	output logic      [1:0]                    o_pin_irq_mode
);
	localparam int NV = intc_pkg::N_VEC;
	localparam int NM = intc_pkg::N_MEM;
	localparam int NP = intc_pkg::N_PIN;
	localparam int IW = intc_pkg::IDX_W;
	localparam int PW = intc_pkg::PC_W;

	// Member flags that exist on this variant
	localparam logic [NM-1:0] MEM_IMPL = HAS_MATCH_B ? 9'h1ff : 9'h1ef;

	logic                  gie_r;
	logic [NV-1:0]         vreq_r;
	logic [NV-1:0]         ven_r;
	logic [NM-1:0]         mreq_r;
	logic [NM-1:0]         men_r;
	logic [3:0]            edge_sel_r;
	logic [IW-1:0]         last_src_r;
	logic [IW-1:0]         win_idx_r;
	logic [PW-1:0]         push_pc_r;
	logic [PW-1:0]         load_pc_r;
	logic                  pop_r;
	logic                  wake_r;
	logic                  ack_r;
	logic [intc_pkg::DATA_W-1:0] rdata_r;
	intc_pkg::seq_state_t  state_r;
	intc_pkg::seq_state_t  state_nxt;

	logic [NP-1:0]         sync_in;
	logic [NP-1:0]         sync_evt;
	logic [1:0]            sync_sel [NP];
	logic [NV-1:0]         vset;
	logic [NM-1:0]         mset;
	logic [NV-1:0]         pend;
	logic [NV-1:0]         svc_clr;
	logic [IW-1:0]         win_idx;
	logic                  win_any;
	logic                  take;
	logic                  wr_go;
	logic [5:0]            word_addr;
	logic [7:0]            wd;
	logic [7:0]            rd_byte;
	logic                  gie_we;
	logic [NV-1:0]         vreq_we;
	logic [NV-1:0]         ven_we;
	logic [NV-1:0]         vreq_wd;
	logic [NV-1:0]         ven_wd;
	logic [NM-1:0]         mreq_we;
	logic [NM-1:0]         men_we;
	logic [NM-1:0]         mreq_wd;
	logic [NM-1:0]         men_wd;
	logic                  edge_we;

	// Bus answers one cycle after the request appears
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
	assign o_avs_readdata    = rdata_r;
	assign word_addr         = i_avs_address[7:2];
	assign wd                = i_avs_writedata[7:0];
	assign wr_go             = i_avs_write & ack_r & i_avs_byteenable[0];

	// Pins, comparators and the peripheral pin all arrive asynchronously
	assign sync_in  = {~i_ext_periph_pin_n, i_comp_out, i_ext_pin};
	assign sync_sel[intc_pkg::S_PIN0] = ven_r[intc_pkg::V_PIN0] ?
		edge_sel_r[1:0] : intc_pkg::EDGE_OFF;
	assign sync_sel[intc_pkg::S_PIN1] = ven_r[intc_pkg::V_PIN1] ?
		edge_sel_r[3:2] : intc_pkg::EDGE_OFF;
	assign sync_sel[intc_pkg::S_CMP0] = intc_pkg::EDGE_BOTH;
	assign sync_sel[intc_pkg::S_CMP1] = intc_pkg::EDGE_BOTH;
	// Inverted pin, so a falling edge on the pin is a rise here
	assign sync_sel[intc_pkg::S_XP]   = intc_pkg::EDGE_RISE;
	assign o_pin_irq_mode = {ven_r[intc_pkg::V_PIN1], ven_r[intc_pkg::V_PIN0]};

	// One synchroniser per asynchronous input
	generate
		for (genvar g = 0; g < NP; g++) begin : g_sync
			edge_sync u_edge_sync (
				.i_ref_clk (i_ref_clk),
				.i_resetn  (i_resetn),
				.i_clk_en  (i_clk_en),
				.i_async   (sync_in[g]),
				.i_sel     (sync_sel[g]),
				.o_event   (sync_evt[g])
			);
		end
	endgenerate

	// Member set strobes, gated by the clock enable
	always_comb begin
		mset = '0;
		mset[intc_pkg::M_T0P] = i_src_evt.timer0_match_p;
		mset[intc_pkg::M_T0A] = i_src_evt.timer0_match_a;
		mset[intc_pkg::M_T1P] = i_src_evt.timer1_match_p;
		mset[intc_pkg::M_T1A] = i_src_evt.timer1_match_a;
		mset[intc_pkg::M_T1B] = i_src_evt.timer1_match_b;
		mset[intc_pkg::M_SIM] = i_src_evt.serial_done;
		mset[intc_pkg::M_XP]  = sync_evt[intc_pkg::S_XP];
		mset[intc_pkg::M_LV]  = i_src_evt.low_voltage;
		mset[intc_pkg::M_DE]  = i_src_evt.eeprom_done;
		mset = mset & MEM_IMPL & {NM{i_clk_en}};
	end

	// Vectored set strobes; a group rises with any enabled member event
	always_comb begin
		vset = '0;
		vset[intc_pkg::V_PIN0] = sync_evt[intc_pkg::S_PIN0];
		vset[intc_pkg::V_PIN1] = sync_evt[intc_pkg::S_PIN1];
		vset[intc_pkg::V_CMP0] = sync_evt[intc_pkg::S_CMP0];
		vset[intc_pkg::V_CMP1] = sync_evt[intc_pkg::S_CMP1];
		vset[intc_pkg::V_TB0]  = i_src_evt.timebase0 & i_clk_en;
		vset[intc_pkg::V_TB1]  = i_src_evt.timebase1 & i_clk_en;
		vset[intc_pkg::V_GRP0] = |(mset[1:0] & men_r[1:0]);
		vset[intc_pkg::V_GRP1] = |(mset[4:2] & men_r[4:2]);
		vset[intc_pkg::V_GRP2] = |(mset[8:7] & men_r[8:7]);
		vset[intc_pkg::V_GRP3] = |(mset[6:5] & men_r[6:5]);
	end

	// Only flags with their own enable compete
	assign pend = vreq_r & ven_r;

	// Scan from lowest rank upward so rank 0 wins last
	always_comb begin
		win_idx = '0;
		win_any = 1'b0;
		for (int r = NV - 1; r >= 0; r--) begin
			if (pend[PRIO_MAP[r*IW +: IW]]) begin
				win_idx = PRIO_MAP[r*IW +: IW];
				win_any = 1'b1;
			end
		end
	end

	// Boundary-aligned take; full stack or global disable hold it off
	assign take = i_clk_en & (state_r == intc_pkg::ST_IDLE) & gie_r & win_any &
		~i_stack_full & i_insn_boundary;

	// Only the serviced vectored flag clears; members stay
	always_comb begin
		svc_clr = '0;
		if (take)
			svc_clr[win_idx] = 1'b1;
	end

	// Software write decode, low byte only
	always_comb begin
		gie_we  = 1'b0;
		vreq_we = '0;
		ven_we  = '0;
		vreq_wd = '0;
		ven_wd  = '0;
		mreq_we = '0;
		men_we  = '0;
		mreq_wd = '0;
		men_wd  = '0;
		edge_we = 1'b0;
		if (wr_go) begin
			unique case (word_addr)
				intc_pkg::OFS_CTRL0: begin
					gie_we  = 1'b1;
					ven_we[2:0]  = 3'h7;
					ven_wd[2:0]  = wd[3:1];
					vreq_we[2:0] = 3'h7;
					vreq_wd[2:0] = wd[6:4];
				end
				intc_pkg::OFS_CTRL1: begin
					ven_we[5:3]  = 3'h7;
					ven_wd[5:3]  = wd[2:0];
					vreq_we[5:3] = 3'h7;
					vreq_wd[5:3] = wd[6:4];
				end
				intc_pkg::OFS_GRP_TB: begin
					ven_we[9:6]  = 4'hf;
					ven_wd[9:6]  = {wd[3], wd[0], wd[2:1]};
					vreq_we[9:6] = 4'hf;
					vreq_wd[9:6] = {wd[7], wd[4], wd[6:5]};
				end
				intc_pkg::OFS_TMR0: begin
					men_we[1:0]  = 2'h3;
					men_wd[1:0]  = wd[1:0];
					mreq_we[1:0] = 2'h3;
					mreq_wd[1:0] = wd[5:4];
				end
				intc_pkg::OFS_TMR1: begin
					men_we[4:2]  = 3'h7;
					men_wd[4:2]  = wd[2:0];
					mreq_we[4:2] = 3'h7;
					mreq_wd[4:2] = wd[6:4];
				end
				intc_pkg::OFS_PERIPH: begin
					men_we[8:5]  = 4'hf;
					men_wd[8:5]  = wd[3:0];
					mreq_we[8:5] = 4'hf;
					mreq_wd[8:5] = wd[7:4];
				end
				intc_pkg::OFS_EDGE: edge_we = 1'b1;
				default: ;
			endcase
		end
	end

	// Register read view; unimplemented positions are zero
	always_comb begin
		rd_byte = intc_pkg::REG_RESET;
		unique case (word_addr)
			intc_pkg::OFS_CTRL0:  rd_byte = {1'b0, vreq_r[2:0], ven_r[2:0], gie_r};
			intc_pkg::OFS_CTRL1:  rd_byte = {1'b0, vreq_r[5:3], 1'b0, ven_r[5:3]};
			intc_pkg::OFS_GRP_TB: rd_byte = {vreq_r[9], vreq_r[7:6], vreq_r[8],
				ven_r[9], ven_r[7:6], ven_r[8]};
			intc_pkg::OFS_TMR0:   rd_byte = {2'b00, mreq_r[1:0], 2'b00, men_r[1:0]};
			intc_pkg::OFS_TMR1:   rd_byte = {1'b0, mreq_r[4:2], 1'b0, men_r[4:2]};
			intc_pkg::OFS_PERIPH: rd_byte = {mreq_r[8:5], men_r[8:5]};
			intc_pkg::OFS_EDGE:   rd_byte = {4'h0, edge_sel_r};
			intc_pkg::OFS_STATUS: rd_byte = {last_src_r, 2'b00, i_stack_full,
				state_r != intc_pkg::ST_IDLE};
			default:              rd_byte = intc_pkg::REG_RESET;
		endcase
	end

	// Bus handshake and read data capture
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ack_r   <= 1'b0;
			rdata_r <= '0;
		end else if (i_clk_en) begin
			ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
			if (i_avs_read & ~ack_r)
				rdata_r <= {24'h000000, rd_byte};
		end
	end

	// Global enable: take clears it, a software write in the same cycle wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn)
			gie_r <= 1'b0;
		else if (i_clk_en) begin
			if (gie_we)
				gie_r <= wd[0];
			else if (take)
				gie_r <= 1'b0;
		end
	end

	// Vectored flags and enables; a hardware set beats any clear
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			vreq_r <= '0;
			ven_r  <= '0;
		end else if (i_clk_en) begin
			vreq_r <= (((vreq_r & ~vreq_we) | (vreq_wd & vreq_we)) & ~svc_clr)
				| vset;
			ven_r  <= (ven_r & ~ven_we) | (ven_wd & ven_we);
		end
	end

	// Member flags are cleared by software alone
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			mreq_r <= '0;
			men_r  <= '0;
		end else if (i_clk_en) begin
			mreq_r <= (((mreq_r & ~mreq_we) | (mreq_wd & mreq_we)) | mset)
				& MEM_IMPL;
			men_r  <= ((men_r & ~men_we) | (men_wd & men_we)) & MEM_IMPL;
		end
	end

	// Edge-select field
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn)
			edge_sel_r <= 4'h0;
		else if (i_clk_en && edge_we)
			edge_sel_r <= wd[3:0];
	end

	// Vectoring sequence: push phase, then load phase
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			intc_pkg::ST_IDLE: if (take) state_nxt = intc_pkg::ST_PUSH;
			intc_pkg::ST_PUSH: state_nxt = intc_pkg::ST_LOAD;
			intc_pkg::ST_LOAD: state_nxt = intc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn)
			state_r <= intc_pkg::ST_IDLE;
		else if (i_clk_en)
			state_r <= state_nxt;
	end

	// Return address and vector are latched at the take
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			push_pc_r  <= '0;
			load_pc_r  <= '0;
			win_idx_r  <= '0;
			last_src_r <= '0;
		end else if (i_clk_en && take) begin
			push_pc_r  <= i_next_pc;
			load_pc_r  <= VEC_TABLE[win_idx*PW +: PW];
			win_idx_r  <= win_idx;
			last_src_r <= win_idx;
		end
	end

	assign o_push    = state_r == intc_pkg::ST_PUSH;
	assign o_load    = state_r == intc_pkg::ST_LOAD;
	assign o_push_pc = push_pc_r;
	assign o_load_pc = load_pc_r;

	// Return pops the saved address; wake follows any set flag
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			pop_r  <= 1'b0;
			wake_r <= 1'b0;
		end else if (i_clk_en) begin
			pop_r  <= i_return_from_irq_instruction;
			wake_r <= (|vreq_r) | (|mreq_r);
		end
	end

	assign o_pop  = pop_r;
	assign o_wake = wake_r;

endmodule : mcu_interrupt_controller

/* common/intc_pkg.sv */
/*
 * Constants, field layouts and carrier types shared by the interrupt
 * controller and its testbench.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses and
 * a single 125 MHz clock domain for all on-chip event sources.
 */
package intc_pkg;

	// Sizes
	localparam int N_VEC  = 10;	// Vectored sources
	localparam int N_MEM  = 9;	// Member sources behind the group flags
	localparam int N_PIN  = 5;	// Asynchronous inputs needing a synchroniser
	localparam int PC_W   = 12;
	localparam int IDX_W  = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// Register word indices
	localparam logic [5:0] OFS_CTRL0  = 6'h00;	// Word index of byte 0x00
	localparam logic [5:0] OFS_CTRL1  = 6'h01;	// 0x04
	localparam logic [5:0] OFS_GRP_TB = 6'h02;	// 0x08
	localparam logic [5:0] OFS_TMR0   = 6'h03;	// 0x0c
	localparam logic [5:0] OFS_TMR1   = 6'h04;	// 0x10
	localparam logic [5:0] OFS_PERIPH = 6'h05;	// 0x14
	localparam logic [5:0] OFS_EDGE   = 6'h06;	// 0x18
	localparam logic [5:0] OFS_STATUS = 6'h07;	// 0x1c
	localparam logic [7:0] REG_RESET  = 8'h00;

	// Vectored source indices
	localparam int V_PIN0 = 0;
	localparam int V_PIN1 = 1;
	localparam int V_CMP0 = 2;
	localparam int V_CMP1 = 3;
	localparam int V_GRP0 = 4;
	localparam int V_GRP1 = 5;
	localparam int V_TB0  = 6;
	localparam int V_TB1  = 7;
	localparam int V_GRP2 = 8;
	localparam int V_GRP3 = 9;

	// Member source indices
	localparam int M_T0P = 0;
	localparam int M_T0A = 1;
	localparam int M_T1P = 2;
	localparam int M_T1A = 3;
	localparam int M_T1B = 4;
	localparam int M_SIM = 5;
	localparam int M_XP  = 6;
	localparam int M_LV  = 7;
	localparam int M_DE  = 8;

	// Synchroniser slots
	localparam int S_PIN0 = 0;
	localparam int S_PIN1 = 1;
	localparam int S_CMP0 = 2;
	localparam int S_CMP1 = 3;
	localparam int S_XP   = 4;

	// Edge-select codes
	localparam logic [1:0] EDGE_OFF  = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_FALL = 2'b10;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

	// Default vector table, entry i at bits [i*PC_W +: PC_W]
	localparam logic [N_VEC*PC_W-1:0] VEC_DEFAULT = {
		12'h028, 12'h024, 12'h020, 12'h01c, 12'h018,
		12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};
	// Default priority: rank r holds the source index at [r*IDX_W +: IDX_W]
	localparam logic [N_VEC*IDX_W-1:0] PRIO_DEFAULT = {
		4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

	// On-chip event strobes, one-cycle pulses on the system clock
	typedef struct packed {
		logic timer0_match_p;
		logic timer0_match_a;
		logic timer1_match_p;
		logic timer1_match_a;
		logic timer1_match_b;
		logic serial_done;
		logic low_voltage;
		logic eeprom_done;
		logic timebase0;
		logic timebase1;
	} src_evt_t;

	typedef enum {ST_IDLE, ST_PUSH, ST_LOAD} seq_state_t;

endpackage : intc_pkg

/* design/edge_sync.sv */
/*
 * Two-flop synchroniser with selectable edge detection.
 * Assumes the input is asynchronous; the event pulse is one clock wide.
 */
`timescale 1ns/10ps
module edge_sync (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_clk_en,
	// Input and edge choice
	input  wire logic       i_async,
	input  wire logic [1:0] i_sel,
	// Detected edge
	output logic            o_event
);
	logic       meta_r;
	logic       sync_r;
	logic       prev_r;
	logic [2:0] prime_r;

	// Synchroniser; first flop feeds only the second
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (i_clk_en) begin
			meta_r <= i_async;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Blocks a false edge until the previous-value flop holds a real level
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn)
			prime_r <= 3'b000;
		else if (i_clk_en)
			prime_r <= {prime_r[1:0], 1'b1};
	end

	// Bit 0 of the select picks rising, bit 1 falling
	assign o_event = i_clk_en & prime_r[2] &
		((sync_r & ~prev_r & i_sel[0]) | (~sync_r & prev_r & i_sel[1]));

endmodule : edge_sync

/* testbench/intc_props.sv */
/* Port-level checks on the interrupt controller.
   Assumes one clock, clock enable held high, and a bind from the bench top. */
`timescale 1ns/10ps
module intc_props (
	// Clock and reset
	input wire logic                        i_ref_clk,
	input wire logic                        i_resetn,
	// Register bus
	input wire logic                        i_avs_read,
	input wire logic [intc_pkg::DATA_W-1:0] o_avs_readdata,
	input wire logic                        o_avs_waitrequest,
	// Events and sequencer
	input wire intc_pkg::src_evt_t          i_src_evt,
	input wire logic                        i_insn_boundary,
	input wire logic [intc_pkg::PC_W-1:0]   i_next_pc,
	input wire logic                        i_stack_full,
	input wire logic                        i_return_from_irq_instruction,
	input wire logic                        o_push,
	input wire logic [intc_pkg::PC_W-1:0]   o_push_pc,
	input wire logic                        o_load,
	input wire logic                        o_pop,
	input wire logic                        o_wake
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	// Vectoring handshake
	a_push_then_load: assert property (o_push |=> o_load)
		else $error("load did not follow push");
	a_load_after_push: assert property (o_load |-> $past(o_push))
		else $error("load without a push before it");
	a_push_pc_saved: assert property (o_push |-> o_push_pc == $past(i_next_pc))
		else $error("pushed address is not the next address");
	a_take_boundary: assert property (o_push |-> $past(i_insn_boundary))
		else $error("take off an instruction boundary");
	// Full stack blocks a take at that edge
	a_stack_hold: assert property (i_stack_full |=> !o_push)
		else $error("push while the stack is full");
	// Each push is followed by load then idle, so no push in the next two cycles
	a_no_back_take: assert property (o_push |=> !o_push [*2])
		else $error("second take too soon");
	a_pop_after_ret: assert property (i_return_from_irq_instruction |=> o_pop)
		else $error("return did not pop");
	// Wake is one cycle behind the flags
	a_wake_on_event: assert property (i_src_evt != '0 |=> ##1 o_wake)
		else $error("event flag did not wake");
	a_read_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |->
		o_avs_readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");

	// Main scenarios
	c_load: cover property (o_load);
	c_pop: cover property (o_pop);
	c_full_then_take: cover property (i_stack_full ##1 !i_stack_full ##[1:10] o_push);
endmodule : intc_props

/* testbench/seq_model.sv */
/* Behavioural program sequencer: program counter and a shallow return stack.
   Assumes one push then one load per vector and returns asked by the bench. */
`timescale 1ns/10ps
module seq_model #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	// From the controller
	input  wire logic        i_push,
	input  wire logic [11:0] i_push_pc,
	input  wire logic        i_load,
	input  wire logic [11:0] i_load_pc,
	// From the bench
	input  wire logic        i_ret_req,
	// To the controller
	output logic             o_insn_boundary,
	output logic [11:0]      o_next_pc,
	output logic             o_stack_full,
	output logic             o_return_from_irq_instruction
);
	logic [11:0] stack_r [DEPTH];
	logic [1:0]  sp_r;
	logic [11:0] pc_r;

	// One cycle in eight is no boundary, so some takes are held back
	assign o_insn_boundary = (pc_r[2:0] != 3'h7);
	assign o_next_pc       = pc_r;
	assign o_stack_full    = (sp_r == 2'(DEPTH));

	// Fetch, push, vector load and return
	always_ff @(posedge i_ref_clk) begin
		o_return_from_irq_instruction <= 1'b0;
		if (!i_resetn) begin
			sp_r <= 2'h0;
			pc_r <= 12'h100;
		end else if (i_push) begin
			stack_r[sp_r] <= i_push_pc;
			sp_r          <= sp_r + 2'h1;
		end else if (i_load) begin
			pc_r <= i_load_pc;
		end else if (i_ret_req && sp_r != 2'h0) begin
			pc_r   <= stack_r[sp_r - 2'h1];
			sp_r   <= sp_r - 2'h1;
			o_return_from_irq_instruction <= 1'b1;
		end else begin
			pc_r <= pc_r + 12'h1;
		end
	end
endmodule : seq_model

/* testbench/mcu_interrupt_controller_tb.sv */
/* Register-level bench for the interrupt controller with a sequencer model.
   Assumes default vectors and priority and the large timer variant. */
`timescale 1ns/10ps
module mcu_interrupt_controller_tb;
	logic               clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0, rdata, q;
	intc_pkg::src_evt_t evt = '0;
	logic [1:0]         pin = 2'b00, comp = 2'b00, pin_mode;
	logic               ret_req = 1'b0, wait_req, bound, full, return_from_irq_instruction, push, load, pop, wake;
	logic               xp_n = 1'b1;
	logic [11:0]        npc, push_pc, load_pc;
	int                 num_errors = 0, n_checks = 0, pushes = 0;
	logic [7:0]         ta [6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h18};
	logic [7:0]         te [6] = '{8'hff, 8'h33, 8'h77, 8'hff, 8'h00, 8'h0f};

	always #4 clk = ~clk;
	// Take counter
	always @(posedge clk) if (push === 1'b1) pushes <= pushes + 1;

	mcu_interrupt_controller u_dut (
		.i_ref_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_src_evt(evt), .i_ext_pin(pin), .i_comp_out(comp), .i_ext_periph_pin_n(xp_n),
		.i_insn_boundary(bound), .i_next_pc(npc), .i_stack_full(full), .i_return_from_irq_instruction(return_from_irq_instruction),
		.o_push(push), .o_push_pc(push_pc), .o_load(load), .o_load_pc(load_pc),
		.o_pop(pop), .o_wake(wake), .o_pin_irq_mode(pin_mode));

	seq_model u_seq (
		.i_ref_clk(clk), .i_resetn(rst_n), .i_push(push), .i_push_pc(push_pc),
		.i_load(load), .i_load_pc(load_pc), .i_ret_req(ret_req), .o_insn_boundary(bound),
		.o_next_pc(npc), .o_stack_full(full), .o_return_from_irq_instruction(return_from_irq_instruction));

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// A bounded wait ran out
	task automatic give_up(input string what);
		num_errors++;
		$display("BAD %s expected done seen timeout", what);
		final_report();
	endtask : give_up

	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		addr  <= a;
		wdata <= d;
		rd    <= ~w;
		wr    <= w;
		do begin
			@(posedge clk);
			k++;
		end while (wait_req !== 1'b0 && k < 20);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wait_req !== 1'b0) give_up("waitrequest");
		@(posedge clk);
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask : rchk

	task automatic wait_load(input logic [11:0] e);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (load !== 1'b1 && k < 60);
		if (load !== 1'b1) give_up("load");
		chk("load_pc", {20'h0, load_pc}, {20'h0, e});
	endtask : wait_load

	// No take may happen for n cycles
	task automatic quiet(input int n);
		int p;
		p = pushes;
		repeat (n) @(posedge clk);
		chk("pushes", pushes, p);
	endtask : quiet

	task automatic ret;
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		@(posedge clk);
	endtask : ret

	task automatic pulse(input intc_pkg::src_evt_t v);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask : pulse

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// Reset values, unmapped word included
		for (int i = 0; i < 9; i++) begin
			rchk(8'(4 * i), 32'h0);
		end
		// Writable bits per register; flags alone wake
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, ta[i], 32'hff);
			rchk(ta[i], {24'h0, te[i]});
			chk("wake", {31'h0, wake}, {31'h0, i < 4});
			bus(1'b1, ta[i], 32'h0);
		end
		// Two time bases at once; disabled, then globally off, then taken by rank
		pulse('{timebase0: 1'b1, timebase1: 1'b1, default: 1'b0});
		rchk(8'h08, 32'h60);
		bus(1'b1, 8'h00, 32'h01);
		quiet(8);
		bus(1'b1, 8'h00, 32'h00);
		bus(1'b1, 8'h08, 32'h66);
		quiet(8);
		bus(1'b1, 8'h00, 32'h01);
		wait_load(12'h01c);
		rchk(8'h00, 32'h00);
		rchk(8'h08, 32'h46);
		bus(1'b1, 8'h00, 32'h01);
		wait_load(12'h020);
		// Stack now full: a new request waits for a return
		pulse('{timebase0: 1'b1, default: 1'b0});
		bus(1'b1, 8'h00, 32'h01);
		quiet(10);
		ret();
		wait_load(12'h01c);
		ret();
		ret();
		// Group flag from a member; service clears the group only
		bus(1'b1, 8'h0c, 32'h02);
		bus(1'b1, 8'h04, 32'h02);
		pulse('{timer0_match_a: 1'b1, default: 1'b0});
		rchk(8'h04, 32'h22);
		bus(1'b1, 8'h00, 32'h01);
		wait_load(12'h014);
		rchk(8'h04, 32'h02);
		rchk(8'h0c, 32'h22);
		ret();
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h04, 32'h0);
		// Every edge code, rising then falling
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 8'h18, 32'(m));
			bus(1'b1, 8'h00, 32'h02);
			pin[0] <= 1'b1;
			repeat (6) @(posedge clk);
			rchk(8'h00, m[0] ? 32'h12 : 32'h02);
			bus(1'b1, 8'h00, 32'h02);
			pin[0] <= 1'b0;
			repeat (6) @(posedge clk);
			rchk(8'h00, m[1] ? 32'h12 : 32'h02);
		end
		chk("pin_mode", {30'h0, pin_mode}, 32'h1);
		bus(1'b1, 8'h18, 32'h01);
		bus(1'b1, 8'h00, 32'h03);
		pin[0] <= 1'b1;
		wait_load(12'h004);
		rchk(8'h00, 32'h02);
		ret();
		// Comparator changes
		bus(1'b1, 8'h00, 32'h00);
		comp <= 2'b11;
		repeat (6) @(posedge clk);
		chk("pin_mode", {30'h0, pin_mode}, 32'h0);
		rchk(8'h00, 32'h40);
		rchk(8'h04, 32'h10);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h00, 32'h49);
		wait_load(12'h00c);
		rchk(8'h00, 32'h08);
		ret();
		// Peripheral pin falls: member flag and its group flag, no take
		bus(1'b1, 8'h14, 32'h02);
		bus(1'b1, 8'h08, 32'h08);
		xp_n <= 1'b0;
		repeat (6) @(posedge clk);
		rchk(8'h14, 32'h22);
		rchk(8'h08, 32'h88);
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h08, 32'h0);
		final_report();
	end
endmodule : mcu_interrupt_controller_tb

bind mcu_interrupt_controller intc_props u_props (
	.i_ref_clk, .i_resetn, .i_avs_read, .o_avs_readdata, .o_avs_waitrequest, .i_src_evt,
	.i_insn_boundary, .i_next_pc, .i_stack_full, .i_return_from_irq_instruction, .o_push, .o_push_pc, .o_load,
	.o_pop, .o_wake);
